// ### core/osc_pkg.sv
// Constants for the oscillator enable and temperature-coefficient trim block.
package osc_pkg;
   // ----------------------------------------------------------------
   // Register indices; byte address is four times the index.
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_TRIM       = 8'h18;
   localparam logic [7:0] IDX_OSC_CONFIG = 8'h1a;
   localparam logic [7:0] IDX_GUARD      = 8'h1b;
   localparam logic [7:0] IDX_CONTROL    = 8'h20;
   localparam logic [7:0] IDX_STATUS     = 8'h21;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h22;
   localparam logic [7:0] IDX_IRQ_MASK   = 8'h23;
   // ----------------------------------------------------------------
   // Field positions.
   // ----------------------------------------------------------------
   localparam int OSC_ENABLE_BIT   = 7;
   localparam int OSC_RESERVED_BIT = 5;
   localparam int TRIM_TC_LSB      = 11;
   localparam int TRIM_FREQ_MSB    = 9;
   localparam int CTRL_PLL_SOURCE_SELECT_BIT  = 0;
   localparam int CTRL_MRE_BIT     = 1;
   localparam int CTRL_REFERENCE_DIVIDER_LSB  = 8;
   localparam int STAT_LOCK_BIT    = 0;
   localparam int STAT_STABLE_BIT  = 1;
   localparam int STAT_CLAIM_BIT   = 2;
   localparam int STAT_TCON_BIT    = 3;
   localparam int IRQ_STABLE_BIT   = 0;
   localparam int IRQ_LOSS_BIT     = 1;
   localparam int IRQ_LOCK_BIT     = 2;
   // ----------------------------------------------------------------
   // Reset values and codes.
   // ----------------------------------------------------------------
   localparam logic       OSC_RESERVED_RESET = 1'b0;
   localparam logic       GUARD_RESET        = 1'b0;
   localparam logic       PLL_SOURCE_SELECT_RESET       = 1'b1;
   localparam logic [7:0] GUARD_UNLOCK_CODE  = 8'h26;
   localparam logic [15:0] TRIM_RESET        = 16'h0000;
   // ----------------------------------------------------------------
   // Timing counts.
   // ----------------------------------------------------------------
   localparam int QUALIFY_EDGES = 4096;
   localparam int LOSS_PLL_TICKS = 64;

   // Byte address of a register index.
   function automatic logic [9:0] addr_of(input logic [7:0] idx);
      addr_of = {idx, 2'b00};
   endfunction

   // Compensation is off for magnitude zero, whatever the sign bit.
   function automatic logic tc_comp_on(input logic [4:0] code);
      tc_comp_on = (code[3:0] != 4'h0);
   endfunction
endpackage

// ### core/osc_link_if.sv
// Signals shared between the oscillator top, its monitor and its divider.
`timescale 1ns/1ps
interface osc_link_if;
   logic       crystal_edge;
   logic       pll_tick;
   logic       rc_tick;
   logic       osc_on;
   logic       restart;
   logic [3:0] ref_div;
   logic       stable;
   logic       loss;
   logic       ref_tick;
   modport top     (output crystal_edge, pll_tick, rc_tick, osc_on, restart, ref_div,
                    input stable, loss, ref_tick);
   modport monitor (input crystal_edge, pll_tick, osc_on, restart, output stable, loss);
   modport divider (input crystal_edge, rc_tick, osc_on, ref_div, output ref_tick);
endinterface

// ### core/crystal_monitor.sv
// Crystal qualification and loss-of-oscillation monitor.
`timescale 1ns/1ps
module crystal_monitor
   import osc_pkg::*;
#(
   parameter int QUALIFY = QUALIFY_EDGES,
   parameter int LOSS    = LOSS_PLL_TICKS
)(
   input wire logic    pclk,
   input wire logic    presetn,
   osc_link_if.monitor link
);
   // Refuses counts that the 16-bit counters cannot hold, at elaboration.
   if (QUALIFY < 1 || QUALIFY > 65535 || LOSS < 2 || LOSS > 65535)
   begin : bad_counts
      $error("crystal_monitor: count out of range");
   end

   logic [15:0] edge_count;
   logic [15:0] gap_count;

   // Counts crystal edges until the oscillation is qualified as stable.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         edge_count  <= 16'h0000;
         link.stable <= 1'b0;
      end
      else if (!link.osc_on || link.restart || link.loss)
      begin
         edge_count  <= 16'h0000;
         link.stable <= 1'b0;
      end
      else if (link.crystal_edge && !link.stable)
      begin
         edge_count <= edge_count + 16'h0001;
         if (edge_count == 16'(QUALIFY - 1))
            link.stable <= 1'b1;
      end
   end

   // Counts PLL ticks between crystal edges; too many means oscillation lost.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gap_count <= 16'h0000;
         link.loss <= 1'b0;
      end
      else
      begin
         link.loss <= 1'b0;
         if (!link.osc_on || link.crystal_edge)
            gap_count <= 16'h0000;
         else if (link.pll_tick)
         begin
            if (gap_count == 16'(LOSS - 1))
            begin
               gap_count <= 16'h0000;
               link.loss <= 1'b1;
            end
            else
               gap_count <= gap_count + 16'h0001;
         end
      end
   end
endmodule

// ### core/reference_divider.sv
// Reference tick source: internal RC ticks or divided crystal edges.
`timescale 1ns/1ps
module reference_divider
   import osc_pkg::*;
(
   input wire logic    pclk,
   input wire logic    presetn,
   osc_link_if.divider link
);
   logic [3:0] div_count;

   // Divides crystal edges by ref_div plus one, one through sixteen.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         div_count     <= 4'h0;
         link.ref_tick <= 1'b0;
      end
      else if (!link.osc_on)
      begin
         div_count     <= 4'h0;
         link.ref_tick <= link.rc_tick; // R6 R16
      end
      else
      begin
         link.ref_tick <= 1'b0;
         if (link.crystal_edge)
         begin
            if (div_count >= link.ref_div) // R14
            begin
               div_count     <= 4'h0;
               link.ref_tick <= 1'b1; // R7
            end
            else
               div_count <= div_count + 4'h1;
         end
      end
   end
endmodule

// ### core/osc_config_top.sv
// Oscillator configuration block with APB registers and trim decode.
`timescale 1ns/1ps
// What this block does
// R1 - Trim codes 00000 and 10000 both switch temperature compensation off.
// R2 - Trim code is sign and magnitude: top bit clear negative, set positive.
// R3 - Oscillator config writes take effect only when unguarded and PLL selected.
// R4 - An accepted oscillator config write clears lock and stable flags.
// R5 - Bit 7 of oscillator config enables the crystal oscillator.
// R6 - With the oscillator off the PLL reference is the internal RC clock.
// R7 - With it on: monitor active, PLL qualifies, reference is divided crystal.
// R8 - Stable flag rises when oscillation is stable; gates crystal clock use. Here it gates nothing; the divider uses crystal edges from enable on.
// R9 - Monitor reset enable plus oscillation loss yields a monitor reset.
// R10 - Once enabled, crystal pins stay claimed until the next reset.
// R11 - Software waits the crystal startup time before pseudo stop.
// R12 - Software writes bit 5 back with its reset value.
// R13 - Software corrects frequency trim after changing the coefficient trim.
// R14 - Crystal clock divided by reference divider plus one, one to sixteen.
// R15 - Guard clears on writing 0x26, any other guard write sets it.
// R16 - Clearing enable drops the stable flag and returns reference to RC.
module osc_config_top
   import osc_pkg::*;
#(
   parameter int QUALIFY = QUALIFY_EDGES,
   parameter int LOSS    = LOSS_PLL_TICKS
)(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [9:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        crystal_clock,
   input  wire logic        internal_rc_clock,
   input  wire logic        pll_output_clock,
   input  wire logic        pll_lock_in,
   output logic             pll_reference_clock,
   output logic             crystal_osc_on,
   output logic             clock_monitor_on,
   output logic             crystal_stable_flag,
   output logic             crystal_pins_claimed,
   output logic             monitor_reset,
   output logic             tc_comp_enable,
   output logic             tc_positive,
   output logic [3:0]       tc_magnitude,
   output logic [9:0]       freq_trim,
   output logic             irq
);
   osc_link_if link ();

   logic       crystal_osc_enable;
   logic       osc_reserved;
   logic       clock_config_guard;
   logic       pll_source_select;
   logic       monitor_reset_enable;
   logic [3:0] reference_divider;
   logic [4:0] temp_coeff_trim_code;
   logic       pll_locked;
   logic [2:0] irq_status;
   logic [2:0] irq_mask;
   logic [2:0] next_irq_status;
   logic [3:0] sync1;
   logic [3:0] sync2;
   logic [3:0] sync3;
   logic       stable_seen;
   logic       setup_phase;
   logic       wr_access;
   logic       osc_wr;
   logic       osc_wr_ok;
   logic       lock_rise;
   logic       stable_rise;
   logic [2:0] irq_events;
   logic       addr_known;
   logic [31:0] read_word;

   // ----------------------------------------------------------------
   // Pin synchronisers and edge detection.
   // ----------------------------------------------------------------

   // Two flops per pin, a third stage only for edge detection.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync1 <= 4'h0;
         sync2 <= 4'h0;
         sync3 <= 4'h0;
      end
      else
      begin
         sync1 <= {pll_lock_in, pll_output_clock, internal_rc_clock, crystal_clock};
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // Rising edges seen on the synchronised pins.
   assign link.crystal_edge = sync2[0] & ~sync3[0];
   assign link.rc_tick      = sync2[1] & ~sync3[1];
   assign link.pll_tick     = sync2[2] & ~sync3[2] & crystal_osc_enable; // R7
   assign lock_rise         = sync2[3] & ~sync3[3];

   // ----------------------------------------------------------------
   // APB decode.
   // ----------------------------------------------------------------

   // Write strobes at the access edge; the oscillator write is gated.
   assign setup_phase = psel & ~penable;
   assign wr_access   = psel & penable & pwrite;
   assign osc_wr      = wr_access && paddr == addr_of(IDX_OSC_CONFIG);
   assign osc_wr_ok   = osc_wr && !clock_config_guard && pll_source_select; // R3
   assign pready      = 1'b1;

   // Address decode for known registers.
   always_comb
   begin
      addr_known = 1'b1;
      read_word  = 32'h00000000;
      case (paddr)
         addr_of(IDX_TRIM):
            read_word = {16'h0000, temp_coeff_trim_code, 1'b0, freq_trim};
         addr_of(IDX_OSC_CONFIG):
            read_word = {24'h000000, crystal_osc_enable, 1'b0, osc_reserved, 5'h00};
         addr_of(IDX_GUARD):
            read_word = {31'h0, clock_config_guard};
         addr_of(IDX_CONTROL):
            read_word = {20'h00000, reference_divider, 6'h00, monitor_reset_enable, pll_source_select};
         addr_of(IDX_STATUS):
            read_word = {28'h0000000, tc_comp_enable, crystal_pins_claimed, crystal_stable_flag, pll_locked};
         addr_of(IDX_IRQ_STATUS):
            read_word = {29'h0, irq_status};
         addr_of(IDX_IRQ_MASK):
            read_word = {29'h0, irq_mask};
         default:
            addr_known = 1'b0;
      endcase
   end

   // Read data and error are captured in the setup cycle.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end
      else if (setup_phase)
      begin
         prdata  <= pwrite ? 32'h00000000 : read_word;
         pslverr <= ~addr_known;
      end
   end

   // ----------------------------------------------------------------
   // Oscillator configuration register.
   // ----------------------------------------------------------------

   // Enable and reserved bit, written only when the write is accepted.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         crystal_osc_enable <= 1'b0;
         osc_reserved       <= OSC_RESERVED_RESET;
      end
      else if (osc_wr_ok) // R3
      begin
         crystal_osc_enable <= pwdata[OSC_ENABLE_BIT]; // R5
         osc_reserved       <= pwdata[OSC_RESERVED_BIT]; // R12
      end
   end

   // Pins stay claimed from the first enabling write until reset.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         crystal_pins_claimed <= 1'b0;
      else if (osc_wr_ok && pwdata[OSC_ENABLE_BIT])
         crystal_pins_claimed <= 1'b1; // R10
   end

   // ----------------------------------------------------------------
   // Guard register.
   // ----------------------------------------------------------------

   // Unlock code clears the guard, any other value sets it.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         clock_config_guard <= GUARD_RESET;
      else if (wr_access && paddr == addr_of(IDX_GUARD))
         clock_config_guard <= (pwdata[7:0] != GUARD_UNLOCK_CODE); // R15
   end

   // ----------------------------------------------------------------
   // Control and trim registers.
   // ----------------------------------------------------------------

   // Source select, divider and monitor reset enable, all guarded.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pll_source_select    <= PLL_SOURCE_SELECT_RESET;
         monitor_reset_enable <= 1'b0;
         reference_divider    <= 4'h0;
      end
      else if (wr_access && paddr == addr_of(IDX_CONTROL) && !clock_config_guard)
      begin
         pll_source_select <= pwdata[CTRL_PLL_SOURCE_SELECT_BIT];
         reference_divider <= pwdata[CTRL_REFERENCE_DIVIDER_LSB +: 4];
         // The reset enable is frozen while the oscillator runs.
         if (!crystal_osc_enable)
            monitor_reset_enable <= pwdata[CTRL_MRE_BIT];
      end
   end

   // Trim codes, written whenever the guard is off.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         temp_coeff_trim_code <= TRIM_RESET[TRIM_TC_LSB +: 5];
         freq_trim            <= TRIM_RESET[TRIM_FREQ_MSB:0];
      end
      else if (wr_access && paddr == addr_of(IDX_TRIM) && !clock_config_guard)
      begin
         temp_coeff_trim_code <= pwdata[TRIM_TC_LSB +: 5]; // R13
         freq_trim            <= pwdata[TRIM_FREQ_MSB:0];
      end
   end

   // Sign and magnitude decode of the coefficient trim.
   assign tc_comp_enable = tc_comp_on(temp_coeff_trim_code); // R1
   assign tc_positive    = temp_coeff_trim_code[4] & tc_comp_enable; // R2
   assign tc_magnitude   = temp_coeff_trim_code[3:0]; // R2

   // ----------------------------------------------------------------
   // Status flags.
   // ----------------------------------------------------------------

   // Lock flag: a new lock wins over a clearing write.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pll_locked <= 1'b0;
      else if (lock_rise)
         pll_locked <= 1'b1;
      else if (osc_wr_ok)
         pll_locked <= 1'b0; // R4
   end

   // Stable flag follows qualification, dropped by write or disable.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         crystal_stable_flag <= 1'b0;
         stable_seen         <= 1'b0;
      end
      else
      begin
         stable_seen <= link.stable;
         if (!crystal_osc_enable || link.loss)
            crystal_stable_flag <= 1'b0; // R16
         else if (stable_rise)
            crystal_stable_flag <= 1'b1; // R8
         else if (osc_wr_ok)
            crystal_stable_flag <= 1'b0; // R4
      end
   end

   assign stable_rise = link.stable & ~stable_seen;

   // Monitor reset pulse on loss while the reset is enabled.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         monitor_reset <= 1'b0;
      else
         monitor_reset <= link.loss & monitor_reset_enable & crystal_osc_enable; // R9
   end

   // ----------------------------------------------------------------
   // Interrupts.
   // ----------------------------------------------------------------

   assign irq_events = {lock_rise, link.loss, stable_rise};

   // Sticky status; a new event wins over a write-one clear.
   always_comb
   begin
      next_irq_status = irq_status;
      if (wr_access && paddr == addr_of(IDX_IRQ_STATUS))
         next_irq_status = irq_status & ~pwdata[2:0];
      next_irq_status = next_irq_status | irq_events;
   end

   // Status and mask registers.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_status <= 3'h0;
         irq_mask   <= 3'h0;
         irq        <= 1'b0;
      end
      else
      begin
         irq_status <= next_irq_status;
         irq        <= |(next_irq_status & irq_mask);
         if (wr_access && paddr == addr_of(IDX_IRQ_MASK))
            irq_mask <= pwdata[2:0];
      end
   end

   // ----------------------------------------------------------------
   // Link to monitor and divider.
   // ----------------------------------------------------------------

   assign link.osc_on   = crystal_osc_enable; // R7
   assign link.restart  = osc_wr_ok;
   assign link.ref_div  = reference_divider;
   assign crystal_osc_on     = crystal_osc_enable;
   assign clock_monitor_on   = crystal_osc_enable; // R7
   assign pll_reference_clock = link.ref_tick;

   crystal_monitor #(
      .QUALIFY (QUALIFY),
      .LOSS    (LOSS)
   ) crystal_monitor_inst (
      .pclk    (pclk),
      .presetn (presetn),
      .link    (link)
   );

   reference_divider reference_divider_inst (
      .pclk    (pclk),
      .presetn (presetn),
      .link    (link)
   );
endmodule

// ### testbench/osc_config_assertions.sv
// Port-level assertions for the oscillator configuration block.
`timescale 1ns/1ps
module osc_config_assertions
   import osc_pkg::*;
#(
   parameter int QUALIFY = QUALIFY_EDGES,
   parameter int LOSS    = LOSS_PLL_TICKS
)(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [9:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        crystal_osc_on,
   input wire logic        clock_monitor_on,
   input wire logic        crystal_stable_flag,
   input wire logic        crystal_pins_claimed,
   input wire logic        monitor_reset,
   input wire logic        tc_comp_enable,
   input wire logic        tc_positive,
   input wire logic [3:0]  tc_magnitude
);
   localparam logic [9:0] A_OSC = {IDX_OSC_CONFIG, 2'b00};
   // ----------------------------------------
   // Checks, all on the bus clock.
   // ----------------------------------------
   default clocking dcb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   AST_TC_OFF: assert property (tc_comp_enable == (tc_magnitude != 4'h0))
      else $error("compensation enable does not follow trim magnitude");
   AST_TC_SIGN: assert property (tc_positive |-> tc_comp_enable)
      else $error("positive shift shown with compensation off");
   AST_MON_ON: assert property (clock_monitor_on == crystal_osc_on)
      else $error("clock monitor does not follow oscillator enable");
   AST_EN_WRITE: assert property ($changed(crystal_osc_on) |->
      $past(psel && penable && pwrite && paddr == A_OSC) && $past(pwdata[OSC_ENABLE_BIT]) == crystal_osc_on)
      else $error("oscillator enable changed without a matching write");
   AST_OFF_DROP: assert property (!crystal_osc_on |-> ##[0:1] !crystal_stable_flag)
      else $error("stable flag set while oscillator off");
   AST_CLAIM_SET: assert property (crystal_osc_on |-> ##[0:1] crystal_pins_claimed)
      else $error("pins not claimed after enable");
   AST_CLAIM_HOLD: assert property (crystal_pins_claimed |=> crystal_pins_claimed)
      else $error("pin claim released before reset");
   AST_MRST_SRC: assert property (monitor_reset |-> $past(crystal_osc_on))
      else $error("monitor reset with oscillator off");
   AST_MRST_DROP: assert property (monitor_reset |-> ##[0:1] !crystal_stable_flag)
      else $error("stable flag kept after oscillation loss");
endmodule

bind osc_config_top osc_config_assertions #(.QUALIFY(QUALIFY), .LOSS(LOSS)) osc_config_assertions_inst (.*);

// ### testbench/crystal_model.sv
// Behavioural crystal, internal RC and PLL sources outside the block.
`timescale 1ns/1ps
module crystal_model
#(
   parameter int CRYSTAL_HALF = 100,
   parameter int RC_HALF      = 200,
   parameter int PLL_HALF     = 60
)(
   input  wire logic crystal_osc_on,
   input  wire logic halt,
   output logic      crystal_clock,
   output logic      internal_rc_clock,
   output logic      pll_output_clock,
   output logic      pll_lock_in
);
   // The crystal swings only while enabled; halt models a dead crystal.
   initial
   begin
      crystal_clock = 1'b0;
      #7;
      forever
      begin
         #(CRYSTAL_HALF);
         if (crystal_osc_on && !halt)
            crystal_clock = ~crystal_clock;
      end
   end

   // The RC runs free; offsets keep edges away from the bus clock edges.
   initial
   begin
      internal_rc_clock = 1'b0;
      #7;
      forever #(RC_HALF) internal_rc_clock = ~internal_rc_clock;
   end

   // The PLL runs free and reports lock once.
   initial
   begin
      pll_output_clock = 1'b0;
      pll_lock_in      = 1'b0;
      #3;
      fork
         forever #(PLL_HALF) pll_output_clock = ~pll_output_clock;
         #500 pll_lock_in = 1'b1;
      join
   end
endmodule

// ### testbench/tb_osc_config_top.sv
// Self-checking bench for the oscillator configuration block.
`timescale 1ns/1ps
module tb_osc_config_top;
   import osc_pkg::*;
   localparam logic [9:0] A_TRIM  = {IDX_TRIM, 2'b00};
   localparam logic [9:0] A_OSC   = {IDX_OSC_CONFIG, 2'b00};
   localparam logic [9:0] A_GUARD = {IDX_GUARD, 2'b00};
   localparam logic [9:0] A_CTRL  = {IDX_CONTROL, 2'b00};
   localparam logic [9:0] A_STAT  = {IDX_STATUS, 2'b00};
   localparam logic [9:0] A_IRQS  = {IDX_IRQ_STATUS, 2'b00};
   localparam logic [9:0] A_MASK  = {IDX_IRQ_MASK, 2'b00};
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, halt, err;
   logic [9:0]  paddr, freq_trim;
   logic [31:0] pwdata, prdata, rd;
   logic        crystal_clock, internal_rc_clock, pll_output_clock, pll_lock_in;
   logic        pll_reference_clock, crystal_osc_on, clock_monitor_on, crystal_stable_flag;
   logic        crystal_pins_claimed, monitor_reset, tc_comp_enable, tc_positive, irq;
   logic [3:0]  tc_magnitude;
   int          n_mismatch, samples_checked;

   osc_config_top #(.QUALIFY(8), .LOSS(4)) osc_config_top_inst (.*);
   crystal_model crystal_model_inst (.*);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic step;
      @(posedge pclk);
      #1;
   endtask

   // One APB transfer; holds the request until pready is seen high.
   task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask

   // Measures the spacing of two reference ticks after a settling tick.
   task automatic gap(input int exp_ns);
      time t0;
      for (int k = 0; k < 3; k++)
      begin
         step();
         for (int i = 0; i < 100 && pll_reference_clock !== 1'b1; i++) step();
         if (k == 1)
            t0 = $time;
      end
      chk(32'($time - t0), exp_ns);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset;
      apb(0, A_OSC, 0);
      chk(rd, 32'h0);
      apb(0, A_CTRL, 0);
      chk(rd, 32'h1);
      apb(0, A_GUARD, 0);
      chk(rd, 32'h0);
      apb(0, 10'h3fc, 0);
      chk(err, 1);
   endtask

   task automatic t_guard;
      apb(1, A_GUARD, 32'h5a);
      apb(0, A_GUARD, 0);
      chk(rd, 32'h1);
      apb(1, A_OSC, 32'h80);
      chk(crystal_osc_on, 0);
      apb(1, A_GUARD, 32'h26);
      apb(0, A_GUARD, 0);
      chk(rd, 32'h0);
      apb(1, A_CTRL, 0);
      apb(1, A_OSC, 32'h80);
      chk(crystal_osc_on, 0);
      apb(1, A_CTRL, 32'h1);
   endtask

   task automatic t_trim;
      logic [4:0] codes [7] = '{5'h00, 5'h10, 5'h0f, 5'h1f, 5'h01, 5'h11, 5'h00};
      logic [31:0] w;
      foreach (codes[i])
      begin
         w = {16'h0, codes[i], 1'b0, 10'h155};
         apb(1, A_TRIM, w);
         chk(tc_comp_enable, codes[i][3:0] != 4'h0);
         chk(tc_positive, codes[i][4] && codes[i][3:0] != 4'h0);
         chk(tc_magnitude, codes[i][3:0]);
         chk(freq_trim, 10'h155);
         apb(0, A_TRIM, 0);
         chk(rd, w);
      end
   endtask

   task automatic t_enable;
      apb(1, A_MASK, 32'h1);
      apb(1, A_CTRL, 32'h0203);
      apb(1, A_OSC, 32'h80);
      chk(crystal_osc_on, 1);
      chk(clock_monitor_on, 1);
      for (int i = 0; i < 400 && crystal_stable_flag !== 1'b1; i++) step();
      chk(crystal_stable_flag, 1);
      repeat (2) step();
      chk(irq, 1);
      apb(1, A_IRQS, 32'h1);
      repeat (2) step();
      chk(irq, 0);
      apb(0, A_STAT, 0);
      chk(rd, 32'h6);
      gap(600);
      apb(1, A_OSC, 32'h80);
      apb(0, A_STAT, 0);
      chk(rd, 32'h4);
   endtask

   task automatic t_loss;
      for (int i = 0; i < 400 && crystal_stable_flag !== 1'b1; i++) step();
      @(posedge pclk);
      halt <= 1'b1;
      for (int i = 0; i < 300 && monitor_reset !== 1'b1; i++) step();
      chk(monitor_reset, 1);
      halt <= 1'b0;
   endtask

   task automatic t_disable;
      apb(1, A_OSC, 32'h0);
      chk(crystal_osc_on, 0);
      chk(crystal_stable_flag, 0);
      chk(crystal_pins_claimed, 1);
      gap(400);
   endtask

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ----------------------------------------
   // Clock, sequence and watchdog
   // ----------------------------------------
   initial
   begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   initial
   begin
      {psel, penable, pwrite, halt, presetn} = 5'h00;
      paddr = 10'h000;
      pwdata = 32'h0;
      n_mismatch = 0;
      samples_checked = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_guard();
      t_trim();
      t_enable();
      t_loss();
      t_disable();
      stop_test();
   end

   initial
   begin
      #100000;
      n_mismatch++;
      stop_test();
   end
endmodule
